// *** design/hrg_generator.sv ***
// health tested random byte generator with physical source and reseeded mixer
`timescale 1ns/10ps
`include "hrg_regs.svh"

module hrg_generator
  import hrg_pkg::*;
#(
  parameter logic [48:0] RESEED_LIMIT = `HRG_RESEED_LIMIT  // shorten for simulation
)
(
  input  wire logic        ref_clk,     // 25 mhz system clock
  input  wire logic        rst,         // synchronous reset, active high
  input  wire logic        raw_bit,     // raw bit of the physical_entropy_generator
  input  wire logic        raw_strobe,  // raw_bit is new this cycle
  input  wire logic        rnd_req,     // consumer takes the offered byte
  output logic      [7:0]  rnd_byte,    // random byte, from a flip-flop
  output logic             rnd_valid,   // rnd_byte may be taken
  output hrg_status_s      status       // latched health status
);

  // ************************************************************
  // declarations
  // ************************************************************
  hrg_state_e    state;          // controller state
  hrg_state_e    next_state;     // controller state next cycle
  hrg_pool_t     pool;           // deterministic state
  hrg_pool_t     next_pool;      // deterministic state next cycle
  logic          last_bit;       // previous raw bit
  logic [5:0]    run_len;        // length of current run of equal bits
  logic [9:0]    win_cnt;        // position in proportion window
  logic [9:0]    ones_cnt;       // ones seen in window so far
  logic [9:0]    ones_total;     // ones including the current bit
  logic [10:0]   boot_cnt;       // raw bits seen during start-up
  logic [8:0]    seed_cnt;       // raw bits folded into current seed
  logic [3:0]    round_cnt;      // mixing rounds done
  logic [48:0]   req_cnt;        // requests since last reseed
  logic          total_fail_now; // repetition test trips this cycle
  logic          defect_now;     // proportion test trips this cycle
  logic          fail_any;       // any failure latched or arriving
  logic          apt_restart;    // internal event that relaunches the window
  logic          win_end;        // last bit of a window arrives

  // ************************************************************
  // mixing function
  // ************************************************************
  // rotate plus nonlinear fold; the and-terms make it non-invertible so
  // past states cannot be rebuilt from the present one. this is a compact
  // stirring core, a full standard construction can replace it in place.
  function automatic hrg_pool_t hrg_mix(input hrg_pool_t s);
    hrg_pool_t rot;
    rot = {s[246:0], s[255:247]};
    return rot ^ {s[127:0], (s[255:128] & s[191:64]) ^ {s[63:0], s[255:192]}};
  endfunction

  // ************************************************************
  // repetition test for total failure
  // ************************************************************
  assign total_fail_now = raw_strobe && (raw_bit == last_bit) &&
                          (run_len == `HRG_REP_CUTOFF - 6'd1);
  // run length tracking, active in every state from reset onward
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      last_bit <= 1'b0;
      run_len  <= 6'd0;
    end
    else if (raw_strobe)
    begin
      last_bit <= raw_bit;
      if (raw_bit != last_bit)
        run_len <= 6'd1;                       // run broken
      else if (run_len != `HRG_REP_CUTOFF)
        run_len <= run_len + 6'd1;             // saturate at cutoff
    end
  end

  // ************************************************************
  // adaptive proportion test
  // ************************************************************
  assign ones_total  = ones_cnt + {9'd0, raw_bit};
  assign win_end     = raw_strobe && (win_cnt == `HRG_APT_WINDOW - 10'd1);
  // a biased window means entropy per bit below the guarded level
  assign defect_now  = win_end && ((ones_total < `HRG_APT_LO) ||
                                   (ones_total > `HRG_APT_HI));
  // every entry to reseed starts a fresh window
  assign apt_restart = (next_state == HRG_RESEED) && (state != HRG_RESEED);
  // window counters; run in all states, so testing is continuous
  always_ff @(posedge ref_clk)
  begin
    if (rst || apt_restart)
    begin
      win_cnt  <= 10'd0;
      ones_cnt <= 10'd0;
    end
    else if (win_end)
    begin
      win_cnt  <= 10'd0;
      ones_cnt <= 10'd0;
    end
    else if (raw_strobe)
    begin
      win_cnt  <= win_cnt + 10'd1;
      ones_cnt <= ones_total;
    end
  end

  // ************************************************************
  // failure and start-up latches
  // ************************************************************
  // set only; nothing but reset clears them
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      status.total_fail   <= 1'b0;
      status.defect       <= 1'b0;
      status.startup_done <= 1'b0;
    end
    else
    begin
      if (total_fail_now)
        status.total_fail <= 1'b1;
      if (defect_now)
        status.defect <= 1'b1;
      if (state == HRG_STARTUP && next_state == HRG_RESEED)
        status.startup_done <= 1'b1;
    end
  end

  assign fail_any = status.total_fail || status.defect || total_fail_now || defect_now;

  // ************************************************************
  // controller
  // ************************************************************
  always_comb
  begin
    next_state = state;
    case (state)
      HRG_STARTUP:
        if (raw_strobe && boot_cnt == `HRG_STARTUP_BITS - 11'd1)
          next_state = HRG_RESEED;
      HRG_RESEED:
        if (raw_strobe && seed_cnt == `HRG_SEED_BITS - 9'd1)
          next_state = HRG_MIX;
      HRG_MIX:
        if (round_cnt == `HRG_MIX_ROUNDS - 4'd1)
          next_state = HRG_READY;
      HRG_READY:
        if (rnd_req)
          // reseed after the request limit, otherwise stir for the next byte
          next_state = (req_cnt == RESEED_LIMIT - 49'd1) ? HRG_RESEED : HRG_MIX;
      HRG_FAIL:
        next_state = HRG_FAIL;
      default:
        next_state = HRG_FAIL;
    endcase
    // a failure overrides everything and is final until reset
    if (fail_any)
      next_state = HRG_FAIL;
  end
  // state register
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      state <= HRG_STARTUP;
    else
      state <= next_state;
  end
  // start-up bit counter
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      boot_cnt <= 11'd0;
    else if (state == HRG_STARTUP && raw_strobe)
      boot_cnt <= boot_cnt + 11'd1;
  end
  // seed bit counter, cleared on each entry to reseed
  always_ff @(posedge ref_clk)
  begin
    if (rst || apt_restart)
      seed_cnt <= 9'd0;
    else if (state == HRG_RESEED && raw_strobe)
      seed_cnt <= seed_cnt + 9'd1;
  end
  // mixing round counter
  always_ff @(posedge ref_clk)
  begin
    if (rst || state != HRG_MIX)
      round_cnt <= 4'd0;
    else
      round_cnt <= round_cnt + 4'd1;
  end
  // request counter, restarted by each reseed
  always_ff @(posedge ref_clk)
  begin
    if (rst || state == HRG_RESEED)
      req_cnt <= 49'd0;
    else if (state == HRG_READY && rnd_req)
      req_cnt <= req_cnt + 49'd1;
  end

  // ************************************************************
  // deterministic state and output byte
  // ************************************************************
  always_comb
  begin
    next_pool = pool;
    case (state)
      // fresh raw bits are folded in on top of stirring
      HRG_RESEED,
      HRG_MIX:
        next_pool = hrg_mix(pool);
      HRG_READY:
        if (rnd_req)
          next_pool = hrg_mix(pool);
      default:
        next_pool = pool;
    endcase
    if (raw_strobe && state != HRG_FAIL && state != HRG_STARTUP)
      next_pool[0] = next_pool[0] ^ raw_bit;
  end
  // pool register; wiped on failure so nothing derived from bad bits survives
  always_ff @(posedge ref_clk)
  begin
    if (rst || fail_any)
      pool <= '0;
    else
      pool <= next_pool;
  end
  // output byte, loaded at the end of mixing
  always_ff @(posedge ref_clk)
  begin
    if (rst || fail_any)
      rnd_byte <= 8'h00;
    else if (state == HRG_MIX && next_state == HRG_READY)
      rnd_byte <= pool[255:248] ^ pool[7:0];
  end
  // offer only when healthy and settled
  assign rnd_valid = (state == HRG_READY) && !fail_any;

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking hrg_cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  valid_needs_pass_a: assert property (rnd_valid |-> status.startup_done)
    else $error("byte offered before start-up pass");
  fail_blocks_a: assert property ((status.total_fail || status.defect) |->
                                  !rnd_valid)
    else $error("byte offered after failure");
  rep_trip_a: assert property (total_fail_now |=>
                               status.total_fail && state == HRG_FAIL)
    else $error("repetition failure not latched");
  fail_wipe_a: assert property (total_fail_now |=> pool == '0 && rnd_byte == 8'h00)
    else $error("state survived a total failure");
  fail_sticky_a: assert property (status.total_fail |=> status.total_fail)
    else $error("failure flag cleared");
  apt_trip_a: assert property (defect_now |=> status.defect ##1 !rnd_valid)
    else $error("proportion defect not latched");
  startup_silent_a: assert property (state == HRG_STARTUP |->
                                     !rnd_valid && !status.startup_done)
    else $error("output during start-up test");
  window_restart_a: assert property (apt_restart |=>
                                     win_cnt == 10'd0 && ones_cnt == 10'd0)
    else $error("window not relaunched on reseed");
  seed_length_a: assert property (state == HRG_RESEED && next_state == HRG_MIX |->
                                  seed_cnt == `HRG_SEED_BITS - 9'd1)
    else $error("seed shorter than required");
  byte_hold_a: assert property (rnd_valid && !rnd_req |=>
                                ($stable(rnd_byte) && rnd_valid) || fail_any)
    else $error("offered byte changed before taken");
  take_stirs_a: assert property (rnd_valid && rnd_req |=>
                                 pool != $past(pool) || fail_any)
    else $error("state not advanced after a take");
  reach_ready_c:  cover property (state == HRG_MIX ##1 state == HRG_READY);
  byte_taken_c:   cover property (rnd_valid && rnd_req);
  reseed_again_c: cover property (state == HRG_READY && rnd_req && next_state == HRG_RESEED);
  fail_seen_c:    cover property (status.startup_done && total_fail_now);

endmodule

// *** design/hrg_pkg.sv ***
// types shared by the health tested random generator
package hrg_pkg;

  // ************************************************************
  // controller states
  // ************************************************************
  typedef enum logic [2:0] {
    HRG_STARTUP,   // power-up online test on raw bits
    HRG_RESEED,    // folding fresh raw bits into the state
    HRG_MIX,       // stirring the state for the next byte
    HRG_READY,     // byte offered to the consumer
    HRG_FAIL       // source dead or defective, output locked
  } hrg_state_e;

  // status seen by the consumer
  typedef struct packed {
    logic startup_done;  // power-up test has passed
    logic total_fail;    // repetition test tripped
    logic defect;        // proportion test tripped
  } hrg_status_s;

  // deterministic state word
  typedef logic [255:0] hrg_pool_t;

endpackage

// *** design/hrg_regs.svh ***
// constants of the health tested random generator: thresholds, counts and sizes
`ifndef HRG_REGS_SVH
`define HRG_REGS_SVH

// ************************************************************
// health test thresholds
// ************************************************************
`define HRG_REP_CUTOFF      6'd32     // identical raw bits in a row that mean a dead source
`define HRG_APT_WINDOW      10'd512   // raw bits per proportion test window
`define HRG_APT_LO          10'd200   // fewest ones tolerated in a window
`define HRG_APT_HI          10'd312   // most ones tolerated in a window
`define HRG_ENTROPY_MILLI   10'd997   // entropy per raw bit, thousandths, the windows guard

// ************************************************************
// start-up, seeding and generation counts
// ************************************************************
`define HRG_STARTUP_BITS    11'd1024  // two full windows before the first seed
`define HRG_SEED_BITS       9'd288    // raw bits folded into every seed
`define HRG_STATE_BITS      256       // width of the deterministic state
`define HRG_MIX_ROUNDS      4'd8      // mixing rounds between two output bytes
`define HRG_RESEED_LIMIT    49'h1_0000_0000_0000  // requests between two reseeds

`endif

// *** tb/hrg_consumer_model.sv ***
// consumer model: the on-chip cpu taking random bytes one at a time
`timescale 1ns/10ps

module hrg_consumer_model
  import hrg_pkg::*;
(
  input  wire logic       ref_clk,    // system clock
  input  wire logic       rst,        // synchronous reset, active high
  input  wire logic       en,         // consumer wants bytes
  input  wire logic [3:0] lag,        // idle cycles before asking, 0 is prompt
  input  wire logic       rnd_valid,  // byte offered
  input  wire logic [7:0] rnd_byte,   // offered byte
  output logic            rnd_req,    // take request
  output logic      [7:0] got_byte,   // last byte taken
  output logic      [7:0] takes       // bytes taken since reset
);
  logic [3:0] wait_cnt;  // cycles the offer has stood unanswered
  logic       take;      // a take happens at this edge

  assign take = rnd_valid && rnd_req;

  // ************************************************************
  // request timing
  // ************************************************************
  // ask only while a byte is offered, drop after each take
  always_ff @(posedge ref_clk)
  begin
    if (rst || !en || !rnd_valid || take)
      wait_cnt <= 4'h0;
    else if (wait_cnt < lag)
      wait_cnt <= wait_cnt + 4'h1;
    rnd_req <= !rst && en && rnd_valid && (wait_cnt >= lag) && !take;
  end

  // ************************************************************
  // captured data
  // ************************************************************
  // one byte per take, nothing grouped
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      takes    <= 8'h00;
      got_byte <= 8'h00;
    end
    else if (take)
    begin
      takes    <= takes + 8'h01;
      got_byte <= rnd_byte;
    end
  end
endmodule

// *** tb/hrg_generator_bench.sv ***
// self-checking bench of the health tested random generator
`timescale 1ns/10ps

module hrg_generator_bench;
  import hrg_pkg::*;
  logic        ref_clk = 1'b0;     // 25 mhz clock
  logic        rst = 1'b1;         // synchronous reset
  logic        raw_bit = 1'b0;     // source bit
  logic        raw_strobe = 1'b0;  // source strobe
  logic        en = 1'b0;          // consumer enable
  logic  [3:0] lag = 4'h0;         // consumer slowness
  logic  [1:0] mode = 2'h0;        // 0 healthy, 1 stuck at zero, 2 biased
  logic  [9:0] pcnt = 10'h000;     // source pattern counter
  logic        rnd_req;            // take request
  logic  [7:0] rnd_byte;           // offered byte
  logic        rnd_valid;          // byte offered
  hrg_status_s status;             // health status
  logic  [7:0] got_byte;           // byte the consumer took
  logic  [7:0] takes;              // consumer take count
  int          miscompares = 0;    // mismatches seen
  int          comparisons = 0;    // checks made
  int          cycles = 0;         // timeout counter

  hrg_generator #(.RESEED_LIMIT(49'h3)) DUT (.ref_clk(ref_clk), .rst(rst), .raw_bit(raw_bit),
    .raw_strobe(raw_strobe), .rnd_req(rnd_req), .rnd_byte(rnd_byte), .rnd_valid(rnd_valid),
    .status(status));

  hrg_consumer_model cpu (.ref_clk(ref_clk), .rst(rst), .en(en), .lag(lag),
    .rnd_valid(rnd_valid), .rnd_byte(rnd_byte), .rnd_req(rnd_req), .got_byte(got_byte),
    .takes(takes));

  initial
  begin
    forever #20 ref_clk = ~ref_clk;
  end

  // ************************************************************
  // entropy source: one bit every cycle
  // ************************************************************
  // healthy xor pattern has 256 ones per 512 and short runs; biased has 448 ones
  always @(posedge ref_clk)
  begin
    pcnt       <= pcnt + 10'h001;
    raw_strobe <= 1'b1;
    raw_bit    <= (mode == 2'h0) ? (pcnt[0] ^ pcnt[2] ^ pcnt[5]) :
                  (mode == 2'h1) ? 1'b0 : (pcnt[2:0] != 3'h0);
  end

  // hang guard, well above the roughly 3000 cycles the tests need
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      miscompares++;
      conclude();
    end
  end

  // ************************************************************
  // compare and helper tasks
  // ************************************************************
  task automatic check_bit(input string what, input logic exp, input logic got);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic do_reset();
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    @(negedge ref_clk);
  endtask

  // counts cycles until a byte is offered, bounded
  task automatic wait_valid(output int n);
    n = 0;
    do
    begin
      @(negedge ref_clk);
      n++;
    end
    while (!rnd_valid && n < 2000);
  endtask

  task automatic wait_take();
    int n;
    n = 0;
    while (!(rnd_valid && rnd_req) && n < 2000)
    begin
      @(negedge ref_clk);
      n++;
    end
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic test_startup();
    int n;
    mode <= 2'h0;
    do_reset();
    repeat (1000) @(negedge ref_clk);
    check_bit("valid during startup", 1'b0, rnd_valid);
    check_bit("startup_done early", 1'b0, status.startup_done);
    wait_valid(n);
    // 1024 start-up bits, 288 seed bits and 8 mix rounds, counted from release
    check_bit("first byte timing", 1'b1, (n + 1000) == 1320);
    check_bit("startup_done", 1'b1, status.startup_done);
    check_bit("first valid", 1'b1, rnd_valid);
    $display("test_startup done");
  endtask

  task automatic test_takes();
    int n;
    logic [7:0] b;
    @(posedge ref_clk);
    en  <= 1'b1;
    lag <= 4'h0;
    @(negedge ref_clk);
    for (int k = 0; k < 3; k++)
    begin
      // offer noted before the take, so a byte that drifts while waiting shows up
      b = rnd_byte;
      wait_take();
      // set up the next offer at the take edge, before it can be asked for
      @(posedge ref_clk);
      en  <= (k < 2);
      lag <= (k == 0) ? 4'h4 : 4'h0;
      wait_valid(n);
      check_byte("taken byte", b, got_byte);
      check_byte("take count", 8'(k + 1), takes);
      if (k < 2)
        check_byte("mix cycles", 8'h09, n[7:0]);
      else
        check_bit("reseed after limit", 1'b1, n == 297);
    end
    $display("test_takes done");
  endtask

  task automatic test_total_fail();
    @(posedge ref_clk);
    mode <= 2'h1;
    repeat (40) @(negedge ref_clk);
    check_bit("total_fail", 1'b1, status.total_fail);
    check_bit("valid after failure", 1'b0, rnd_valid);
    check_byte("byte wiped", 8'h00, rnd_byte);
    @(posedge ref_clk);
    mode <= 2'h0;
    en   <= 1'b1;
    repeat (600) @(negedge ref_clk);
    check_bit("still locked", 1'b0, rnd_valid);
    check_bit("total_fail kept", 1'b1, status.total_fail);
    check_byte("no take while blocked", 8'h03, takes);
    @(posedge ref_clk);
    en <= 1'b0;
    $display("test_total_fail done");
  endtask

  task automatic test_defect();
    mode <= 2'h2;
    do_reset();
    repeat (600) @(negedge ref_clk);
    check_bit("defect", 1'b1, status.defect);
    check_bit("no total_fail", 1'b0, status.total_fail);
    check_bit("startup refused", 1'b0, status.startup_done);
    check_bit("valid on defect", 1'b0, rnd_valid);
    $display("test_defect done");
  endtask

  task automatic conclude();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    test_startup();
    test_takes();
    test_total_fail();
    test_defect();
    conclude();
  end
endmodule
